// *** hdl/sqc_decode.sv ***
// decoder of step configuration fields into mux and gain controls
`timescale 1ns/1ps
module sqc_decode
	import sqc_pkg::*;
(
	input  wire logic [15:0] cfg,          // stored configuration
	output sqc_src_type      src,          // positive source kind
	output logic [2:0]       ext_sel,      // external input index
	output logic             neg_ext,      // negative to input seven
	output logic             neg_auto,     // negative chosen automatically
	output logic [2:0]       gain          // gain multiplier
);
	logic [3:0] pos;
	assign pos = cfg[POS_HI:POS_LO];
	// positive source and negative selection
	always_comb begin
		ext_sel  = pos[2:0];
		neg_auto = 1'b1;
		if (pos <= POS_LAST_EXT) begin
			src      = SRC_EXTERNAL;
			neg_auto = 1'b0;
		end else if (pos == POS_TEMP) begin
			src = SRC_TEMP;
		end else if (pos == POS_SHORT) begin
			src = SRC_SHORT;
		end else if (pos == POS_TEST) begin
			src = SRC_TEST;
		end else begin
			src = SRC_SUPPLY;
		end
		neg_ext = cfg[NEG_BIT] & ~neg_auto;
	end
	// gain map, both upper codes give four
	always_comb begin
		case (cfg[GAIN_HI:GAIN_LO])
			2'b00:   gain = GAIN_X1;
			2'b01:   gain = GAIN_X2;
			default: gain = GAIN_X4;
		endcase
	end
endmodule

// *** hdl/sqc_pkg.sv ***
// package for the step 11 sequencer configuration register
package sqc_pkg;
	localparam int            ADDR_W          = 8;
	localparam int            DATA_W          = 16;
	localparam logic [7:0]    STEP11_CFG_ADDR = 8'h9B;
	localparam logic [15:0]   STEP11_CFG_RST  = 16'h000B;
	localparam int            EN_BIT          = 15;
	localparam int            GAIN_HI         = 14;
	localparam int            GAIN_LO         = 13;
	localparam int            NEG_BIT         = 4;
	localparam int            POS_HI          = 3;
	localparam int            POS_LO          = 0;
	localparam logic [15:0]   WRITABLE_MASK   = 16'hE01F;
	localparam logic [3:0]    POS_LAST_EXT    = 4'h7;
	localparam logic [3:0]    POS_TEMP        = 4'h8;
	localparam logic [3:0]    POS_SHORT       = 4'h9;
	localparam logic [3:0]    POS_TEST        = 4'hB;
	// source kinds driven to the analog mux
	typedef enum logic [2:0] {
		SRC_EXTERNAL,
		SRC_TEMP,
		SRC_SHORT,
		SRC_TEST,
		SRC_SUPPLY
	} sqc_src_type;
	// gain multiplier codes: 1, 2, 4
	localparam logic [2:0]    GAIN_X1         = 3'h1;
	localparam logic [2:0]    GAIN_X2         = 3'h2;
	localparam logic [2:0]    GAIN_X4         = 3'h4;
	// output values while reset is held; decoded controls match the register reset value, read data hold zero
	localparam logic [2:0]    GAIN_RST        = GAIN_X1;
	localparam sqc_src_type   POS_SRC_RST     = SRC_TEST;
	localparam logic [2:0]    EXT_SEL_RST     = 3'h3;
	localparam logic          NEG_EXT_RST     = 1'b0;
	localparam logic          NEG_AUTO_RST    = 1'b1;
	localparam logic [15:0]   RDATA_IDLE      = 16'h0000;
endpackage

// *** hdl/sqc_step11_cfg.sv ***
// step 11 configuration register with decoded sequencer controls
`timescale 1ns/1ps
module sqc_step11_cfg
	import sqc_pkg::*;
(
	input  wire logic                    MCLK,       // 50 MHz clock
	input  wire logic                    RST_N,      // async reset, low
	input  wire logic                    CLK_EN,     // freezes state when low
	input  wire logic [sqc_pkg::ADDR_W-1:0] ADDR,    // register address
	input  wire logic [sqc_pkg::DATA_W-1:0] WDATA,   // write data
	input  wire logic                    WR,         // write strobe
	input  wire logic                    RD,         // read strobe
	output logic [sqc_pkg::DATA_W-1:0]   RDATA,      // read data, next cycle
	output logic                         STEP_EN,    // step enabled
	output logic [2:0]                   GAIN,       // gain multiplier
	output sqc_pkg::sqc_src_type         POS_SRC,    // positive source kind
	output logic [2:0]                   EXT_SEL,    // external input index
	output logic                         NEG_EXT,    // negative on input seven
	output logic                         NEG_AUTO    // negative automatic
);
	import sqc_pkg::*;
	logic [15:0]  cfg_r;
	logic         hit;
	sqc_src_type  src_nxt;
	logic [2:0]   ext_nxt;
	logic         negx_nxt;
	logic         nega_nxt;
	logic [2:0]   gain_nxt;
	assign hit = (ADDR == STEP11_CFG_ADDR);
	// configuration storage, reserved bits held zero
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			cfg_r <= STEP11_CFG_RST;
		end else if (CLK_EN && WR && hit) begin
			cfg_r <= WDATA & WRITABLE_MASK;
		end
	end
	// read port, zero for unmapped addresses
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			RDATA <= RDATA_IDLE;
		end else if (CLK_EN) begin
			RDATA <= (RD && hit) ? cfg_r : RDATA_IDLE;
		end
	end
	sqc_decode u_dec (
		.cfg      (cfg_r),
		.src      (src_nxt),
		.ext_sel  (ext_nxt),
		.neg_ext  (negx_nxt),
		.neg_auto (nega_nxt),
		.gain     (gain_nxt)
	);

	// step enable toward the sequencer
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			STEP_EN <= 1'b0;
		end else if (CLK_EN) begin
			STEP_EN <= cfg_r[EN_BIT];
		end
	end

	// gain multiplier toward the converter
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			GAIN <= GAIN_RST;
		end else if (CLK_EN) begin
			GAIN <= gain_nxt;
		end
	end

	// positive source kind toward the mux
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			POS_SRC <= POS_SRC_RST;
		end else if (CLK_EN) begin
			POS_SRC <= src_nxt;
		end
	end

	// external input index toward the mux
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			EXT_SEL <= EXT_SEL_RST;
		end else if (CLK_EN) begin
			EXT_SEL <= ext_nxt;
		end
	end

	// negative input on input seven, masked when automatic
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			NEG_EXT <= NEG_EXT_RST;
		end else if (CLK_EN) begin
			NEG_EXT <= negx_nxt;
		end
	end

	// automatic negative input flag
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			NEG_AUTO <= NEG_AUTO_RST;
		end else if (CLK_EN) begin
			NEG_AUTO <= nega_nxt;
		end
	end

	// a mapped write lands with reserved bits cleared
	wr_store_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		CLK_EN && WR && hit
		|=> cfg_r == ($past(WDATA) & WRITABLE_MASK))
		else $error("write not stored");

	// reserved bits never read or stored as one
	rsv_zero_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		RDATA[12:5] == 8'h00
		&& cfg_r[12:5] == 8'h00)
		else $error("reserved bits nonzero");

	// a mapped read returns the stored word
	rd_data_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		CLK_EN && RD && hit
		|=> RDATA == $past(cfg_r))
		else $error("bad read data");

	// read data stay zero without a mapped read
	rd_idle_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		CLK_EN && !(RD && hit)
		|=> RDATA == RDATA_IDLE)
		else $error("read data not idle");

	// a write to another address leaves the word alone
	miss_wr_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		CLK_EN && WR && !hit
		|=> $stable(cfg_r))
		else $error("unmapped write stored");

	// write then read back to back returns the new word
	rd_back_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		CLK_EN && WR && hit ##1 CLK_EN && RD && hit
		|=> RDATA == ($past(WDATA, 2) & WRITABLE_MASK))
		else $error("read back wrong");

	// stored word frozen while the clock enable is low
	freeze_cfg_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		!CLK_EN
		|=> $stable(cfg_r) && $stable(RDATA))
		else $error("word moved while frozen");

	// step enable, gain, source kind and input seven negative frozen while the clock enable is low
	freeze_out_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		!CLK_EN
		|=> $stable(STEP_EN) && $stable(GAIN) && $stable(POS_SRC) && $stable(NEG_EXT))
		else $error("output moved while frozen");

	// enable output follows the stored bit
	en_follow_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		CLK_EN
		|=> STEP_EN == $past(cfg_r[EN_BIT]))
		else $error("enable mismatch");

	// enable written reaches the output two edges on
	en_lag_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		CLK_EN && WR && hit ##1 CLK_EN
		|=> STEP_EN == $past(WDATA[EN_BIT], 2))
		else $error("enable late");

	// upper gain codes both give four
	gain_map_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		CLK_EN && cfg_r[14]
		|=> GAIN == GAIN_X4)
		else $error("gain not four");

	// gain code zero gives one
	gain_one_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		CLK_EN && cfg_r[14:13] == 2'b00
		|=> GAIN == GAIN_X1)
		else $error("gain not one");

	// gain code one gives two
	gain_two_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		CLK_EN && cfg_r[14:13] == 2'b01
		|=> GAIN == GAIN_X2)
		else $error("gain not two");

	// written upper gain reaches the output two edges on
	gain_lag_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		CLK_EN && WR && hit && WDATA[14] ##1 CLK_EN
		|=> GAIN == GAIN_X4)
		else $error("gain late");

	// negative bit honoured for external codes
	neg_sel_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		CLK_EN && cfg_r[3:0] <= 4'h7
		|=> NEG_EXT == $past(cfg_r[NEG_BIT]))
		else $error("negative wrong");

	// external codes route the indexed input
	ext_route_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		CLK_EN && !cfg_r[3]
		|=> POS_SRC == SRC_EXTERNAL && EXT_SEL == $past(cfg_r[2:0]))
		else $error("external route wrong");

	// external codes keep the negative input manual
	ext_manual_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		CLK_EN && !cfg_r[3]
		|=> !NEG_AUTO)
		else $error("external negative automatic");

	// written external code reaches the mux two edges on
	src_lag_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		CLK_EN && WR && hit && !WDATA[3] ##1 CLK_EN
		|=> POS_SRC == SRC_EXTERNAL)
		else $error("source late");

	// code eight picks the temperature sensor
	temp_src_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		CLK_EN && cfg_r[3:0] == POS_TEMP
		|=> POS_SRC == SRC_TEMP && NEG_AUTO)
		else $error("temp wrong");

	// code nine shorts the input
	short_src_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		CLK_EN && cfg_r[3:0] == POS_SHORT
		|=> POS_SRC == SRC_SHORT && NEG_AUTO)
		else $error("short wrong");

	// code eleven picks the test generator
	test_src_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		CLK_EN && cfg_r[3:0] == POS_TEST
		|=> POS_SRC == SRC_TEST && NEG_AUTO)
		else $error("test wrong");

	// remaining upper codes pick a supply monitor
	supply_src_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		CLK_EN && (cfg_r[3:0] == 4'hA || cfg_r[3:2] == 2'b11)
		|=> POS_SRC == SRC_SUPPLY && NEG_AUTO)
		else $error("supply wrong");

	// upper codes ignore the negative bit
	neg_ignore_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		CLK_EN && cfg_r[3]
		|=> NEG_AUTO && !NEG_EXT)
		else $error("negative bit used");

	// automatic negative never drives input seven
	auto_neg_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		NEG_AUTO
		|-> !NEG_EXT)
		else $error("negative bit not ignored");

	// mapped write seen
	wr_cov: cover property (@(posedge MCLK) disable iff (!RST_N)
		CLK_EN && WR && hit);

	// mapped read seen
	rd_cov: cover property (@(posedge MCLK) disable iff (!RST_N)
		CLK_EN && RD && hit);

	// enabled step on an external input
	en_cov: cover property (@(posedge MCLK) disable iff (!RST_N)
		STEP_EN && POS_SRC == SRC_EXTERNAL);

	// automatic negative on a supply code
	auto_cov: cover property (@(posedge MCLK) disable iff (!RST_N)
		NEG_AUTO && POS_SRC == SRC_SUPPLY);

	// write refused while frozen
	frz_cov: cover property (@(posedge MCLK) disable iff (!RST_N)
		!CLK_EN && WR && hit);
endmodule

// *** test/sqc_step11_cfg_tb.sv ***
// self-checking bench for the step 11 configuration register
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module sqc_step11_cfg_tb;
	import sqc_pkg::*;
	logic        MCLK, RST_N, CLK_EN, WR, RD, STEP_EN, NEG_EXT, NEG_AUTO;
	logic [7:0]  ADDR;
	logic [15:0] WDATA, RDATA, shadow, v;
	logic [2:0]  GAIN, EXT_SEL;
	sqc_src_type POS_SRC;
	int          num_errors, num_checks;
	sqc_step11_cfg dut_u (.MCLK(MCLK), .RST_N(RST_N), .CLK_EN(CLK_EN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
		.RD(RD), .RDATA(RDATA), .STEP_EN(STEP_EN), .GAIN(GAIN), .POS_SRC(POS_SRC), .EXT_SEL(EXT_SEL),
		.NEG_EXT(NEG_EXT), .NEG_AUTO(NEG_AUTO));
	// free-running clock
	initial begin
		MCLK = 1'b0;
		forever #10 MCLK = ~MCLK;
	end
	// expected positive source kind for a code
	function automatic sqc_src_type exp_src(input logic [3:0] p);
		if (p <= POS_LAST_EXT) return SRC_EXTERNAL;
		if (p == POS_TEMP) return SRC_TEMP;
		if (p == POS_SHORT) return SRC_SHORT;
		if (p == POS_TEST) return SRC_TEST;
		return SRC_SUPPLY;
	endfunction
	// one strobe cycle, ends where read data stand
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge MCLK);
		ADDR <= a;
		WDATA <= d;
		WR <= w;
		RD <= ~w;
		@(posedge MCLK);
		WR <= 1'b0;
		RD <= 1'b0;
		@(negedge MCLK);
	endtask
	// decoded outputs, read back and idle read data
	task automatic chk_all(input string t);
		@(negedge MCLK);
		`CHK("STEP_EN", shadow[15], STEP_EN)
		`CHK("GAIN", (shadow[14] ? GAIN_X4 : (shadow[13] ? GAIN_X2 : GAIN_X1)), GAIN)
		`CHK("NEG_EXT", shadow[4] & ~shadow[3], NEG_EXT)
		`CHK("NEG_AUTO", shadow[3], NEG_AUTO)
		`CHK("EXT_SEL", shadow[2:0], EXT_SEL)
		`CHK("POS_SRC", exp_src(shadow[3:0]), POS_SRC)
		bus(1'b0, STEP11_CFG_ADDR, 16'h0000);
		`CHK("RDATA", shadow, RDATA)
		@(negedge MCLK);
		`CHK("RDATA idle", 16'h0000, RDATA)
		$display("test %s done", t);
	endtask
	// verdict and end of run
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// hang guard
	initial begin
		#1000000;
		num_errors++;
		finish_test();
	end
	// main sequence
	initial begin
		{RST_N, WR, RD, ADDR, WDATA} = '0;
		CLK_EN = 1'b1;
		num_errors = 0;
		num_checks = 0;
		v = 16'($urandom(68895));
		repeat (10) @(posedge MCLK);
		RST_N <= 1'b1;
		shadow = STEP11_CFG_RST;
		chk_all("reset");
		for (int i = 0; i < 48; i++) begin
			v = 16'($urandom);
			if (i < 16) v[3:0] = 4'(i);
			if (i == 16) v = 16'hFFFF;
			bus(1'b1, STEP11_CFG_ADDR, v);
			shadow = v & WRITABLE_MASK;
			chk_all("write");
		end
		v = 16'($urandom);
		if (v[7:0] == STEP11_CFG_ADDR) v[0] = ~v[0];
		bus(1'b1, v[7:0], ~shadow);
		bus(1'b0, v[7:0], 16'h0000);
		`CHK("RDATA unmapped", 16'h0000, RDATA)
		chk_all("unmapped");
		@(posedge MCLK);
		CLK_EN <= 1'b0;
		bus(1'b1, STEP11_CFG_ADDR, ~shadow);
		@(posedge MCLK);
		CLK_EN <= 1'b1;
		chk_all("clock enable");
		bus(1'b1, STEP11_CFG_ADDR, 16'hFFF0);
		@(posedge MCLK);
		RST_N <= 1'b0;
		repeat (2) @(posedge MCLK);
		RST_N <= 1'b1;
		shadow = STEP11_CFG_RST;
		chk_all("second reset");
		finish_test();
	end
endmodule
